// File: src/upco_defines.svh
// Constants for the pin control block
`ifndef UPCO_DEFINES_SVH
`define UPCO_DEFINES_SVH
`define UPCO_MCR_LOOP_BIT 3
`define UPCO_MCR_W 8
`define UPCO_MCR_RST 8'h00
`define UPCO_BUS_16 1'b1
`define UPCO_BUS_68 1'b0
`define UPCO_RST_SYNC_W 2
`define UPCO_MCR_RTS_BIT 1
`define UPCO_MCR_DTR_BIT 0
`define UPCO_NCHAN 2
`define UPCO_CHAN_A 0
`define UPCO_CHAN_B 1
`define UPCO_STAT_W 4
`endif

// File: src/upco_pkg.sv
// Types for the pin control block
package upco_pkg;
   typedef enum logic [0:0] {
      UPCO_MODE_68 = 1'b0,
      UPCO_MODE_16 = 1'b1
   } upco_bus_mode_t;
   typedef struct packed {
      logic cs_a_n;
      logic cs_b_n;
      logic rd_n;
      logic wr_n;
      logic rw_n;
      logic a3;
   } upco_bus_in_t;
   typedef struct packed {
      logic sel_a;
      logic sel_b;
      logic rd;
      logic wr;
   } upco_bus_req_t;
   typedef struct packed {
      logic dsr;
      logic cd;
      logic ri;
      logic cts;
   } upco_modem_stat_t;
endpackage

// File: src/upco_chan_out.sv
// Per-channel auxiliary output and interrupt enable from the modem control bit
`timescale 1ns/1ns
`include "upco_defines.svh"
module upco_chan_out (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [`UPCO_MCR_W-1:0] modem_ctrl_reg,
   input wire logic irq_req,
   output logic aux_out_n,
   output logic irq_out,
   output logic irq_oe
);
   wire gate_on;
   assign gate_on = modem_ctrl_reg[`UPCO_MCR_LOOP_BIT];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aux_out_n <= 1'b1;
         irq_oe <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         // Aux pin and irq enable share one bit, so aux is no free output
         aux_out_n <= ~gate_on;
         irq_oe <= gate_on;
         irq_out <= irq_req & gate_on;
      end
   end
endmodule

// File: src/upco_top.sv
// Pin-level control: aux outputs, irq gating, channel B modem pins, bus select
`timescale 1ns/1ns
`include "upco_defines.svh"
module upco_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic osc_in,
   input wire logic bus_sel,
   input wire logic reset_pin,
   input wire upco_pkg::upco_bus_in_t bus_in,
   input wire logic [`UPCO_MCR_W-1:0] modem_ctrl_reg_a,
   input wire logic [`UPCO_MCR_W-1:0] modem_ctrl_reg_b,
   input wire logic irq_req_a,
   input wire logic irq_req_b,
   input wire logic tx_bit_b,
   input wire logic ser_in_b,
   input wire logic clr_send_b_n,
   input wire logic set_ready_b_n,
   input wire logic carrier_det_b_n,
   input wire logic ring_ind_b_n,
   output logic osc_out,
   output logic aux_out_a_n,
   output logic aux_out_b_n,
   output logic irq_out_a,
   output logic irq_out_a_oe,
   output logic irq_out_b,
   output logic irq_out_b_oe,
   output logic ser_out_b,
   output logic req_send_b_n,
   output logic term_ready_b_n,
   output logic rx_bit_b,
   output logic tx_allowed_b,
   output upco_pkg::upco_modem_stat_t modem_stat_b,
   output upco_pkg::upco_bus_mode_t bus_mode,
   output upco_pkg::upco_bus_req_t bus_req,
   output logic dev_reset
);
   import upco_pkg::*;

   upco_bus_mode_t next_mode;
   upco_bus_req_t next_req;
   logic pin_reset_act;
   logic [`UPCO_RST_SYNC_W-1:0] rst_hold;
   wire int_rst;
   wire mode16;

   // Host strobe decode, one named wire per term
   wire cs_a_on;
   wire cs_b_on;
   wire any_cs16;
   wire sel_a16;
   wire sel_b16;
   wire rd16;
   wire wr16;
   wire sel_a68;
   wire sel_b68;
   wire rd68;
   wire wr68;

   // Channel-indexed views of the per-channel pins
   wire [`UPCO_NCHAN-1:0][`UPCO_MCR_W-1:0] mcr_v;
   wire [`UPCO_NCHAN-1:0] irq_req_v;
   wire [`UPCO_NCHAN-1:0] aux_n_v;
   wire [`UPCO_NCHAN-1:0] irq_v;
   wire [`UPCO_NCHAN-1:0] irq_oe_v;

   // Channel B modem pins, in the bit order of the status struct
   wire [`UPCO_STAT_W-1:0] stat_pin_n;
   wire [`UPCO_STAT_W-1:0] stat_act;
   wire rts_on;
   wire dtr_on;
   wire cts_on;

   assign mode16 = (bus_sel == `UPCO_BUS_16);
   assign next_mode = mode16 ? UPCO_MODE_16 : UPCO_MODE_68;
   // Reset pin polarity follows the bus select
   assign pin_reset_act = mode16 ? reset_pin : ~reset_pin;
   // Either source clears the pins; bus mode survives a pin reset
   assign int_rst = ~reset_n | rst_hold[0];

   // 16 mode: separate strobes and per-channel selects
   assign cs_a_on = ~bus_in.cs_a_n;
   assign cs_b_on = ~bus_in.cs_b_n;
   assign any_cs16 = cs_a_on | cs_b_on;
   assign sel_a16 = cs_a_on;
   assign sel_b16 = cs_b_on;
   assign rd16 = ~bus_in.rd_n & any_cs16;
   assign wr16 = ~bus_in.wr_n & any_cs16;
   // 68 mode: one select, direction line, a3 picks the channel
   assign sel_a68 = cs_a_on & ~bus_in.a3;
   assign sel_b68 = cs_a_on & bus_in.a3;
   assign rd68 = cs_a_on & bus_in.rw_n;
   assign wr68 = cs_a_on & ~bus_in.rw_n;
   assign next_req = mode16 ? {sel_a16, sel_b16, rd16, wr16}
      : {sel_a68, sel_b68, rd68, wr68};

   // Control bits set means asserted, pin low
   assign rts_on = modem_ctrl_reg_b[`UPCO_MCR_RTS_BIT];
   assign dtr_on = modem_ctrl_reg_b[`UPCO_MCR_DTR_BIT];
   assign cts_on = ~clr_send_b_n;
   assign stat_pin_n = {set_ready_b_n, carrier_det_b_n, ring_ind_b_n, clr_send_b_n};

   // Status only; nothing in the data path reads these
   for (genvar s = 0; s < `UPCO_STAT_W; s++) begin : g_stat
      assign stat_act[s] = ~stat_pin_n[s];
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bus_mode <= UPCO_MODE_68;
      end else begin
         bus_mode <= next_mode;
      end
   end

   // Two-stage pipe on the reset pin; only the last stage is used
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rst_hold <= '0;
         dev_reset <= 1'b1;
      end else begin
         rst_hold <= {pin_reset_act, rst_hold[`UPCO_RST_SYNC_W-1:1]};
         dev_reset <= rst_hold[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         bus_req <= '0;
      end else begin
         bus_req <= next_req;
      end
   end

   // Registered copy of the reference; costs one cycle of skew
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         osc_out <= 1'b0;
      end else begin
         osc_out <= osc_in;
      end
   end

   // Transmitter sits at mark through any reset
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         ser_out_b <= 1'b1;
      end else begin
         ser_out_b <= tx_bit_b;
      end
   end

   // Line idles high, so a missing partner reads as idle
   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         rx_bit_b <= 1'b1;
      end else begin
         rx_bit_b <= ser_in_b;
      end
   end

   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         req_send_b_n <= 1'b1;
         term_ready_b_n <= 1'b1;
      end else begin
         req_send_b_n <= ~rts_on;
         term_ready_b_n <= ~dtr_on;
      end
   end

   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         tx_allowed_b <= 1'b0;
      end else begin
         tx_allowed_b <= cts_on;
      end
   end

   always_ff @(posedge core_clk) begin
      if (int_rst) begin
         modem_stat_b <= '0;
      end else begin
         modem_stat_b <= stat_act;
      end
   end

   assign mcr_v = {modem_ctrl_reg_b, modem_ctrl_reg_a};
   assign irq_req_v = {irq_req_b, irq_req_a};

   // One gate cell per channel; each follows only its own bit 3
   for (genvar c = 0; c < `UPCO_NCHAN; c++) begin : g_chan
      upco_chan_out u_chan (
         .core_clk(core_clk),
         .rst(int_rst),
         .modem_ctrl_reg(mcr_v[c]),
         .irq_req(irq_req_v[c]),
         .aux_out_n(aux_n_v[c]),
         .irq_out(irq_v[c]),
         .irq_oe(irq_oe_v[c])
      );
   end

   assign aux_out_a_n = aux_n_v[`UPCO_CHAN_A];
   assign irq_out_a = irq_v[`UPCO_CHAN_A];
   assign irq_out_a_oe = irq_oe_v[`UPCO_CHAN_A];
   assign aux_out_b_n = aux_n_v[`UPCO_CHAN_B];
   assign irq_out_b = irq_v[`UPCO_CHAN_B];
   assign irq_out_b_oe = irq_oe_v[`UPCO_CHAN_B];
endmodule

// File: test/upco_assertions.sv
// Checker for the pin control block
`timescale 1ns/1ns
module upco_assertions (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic bus_sel,
   input wire logic reset_pin,
   input wire logic [7:0] modem_ctrl_reg_a,
   input wire logic [7:0] modem_ctrl_reg_b,
   input wire logic clr_send_b_n,
   input wire logic aux_out_a_n,
   input wire logic aux_out_b_n,
   input wire logic irq_out_a_oe,
   input wire logic irq_out_b_oe,
   input wire logic req_send_b_n,
   input wire logic term_ready_b_n,
   input wire logic tx_allowed_b,
   input wire upco_pkg::upco_bus_mode_t bus_mode,
   input wire logic dev_reset
);
   import upco_pkg::*;
   wire pin_act = bus_sel ~^ reset_pin;
   default clocking @(posedge core_clk); endclocking
   // Pin reset clears outputs on the same edge that sets dev_reset
   default disable iff (!reset_n || dev_reset || pin_act);
   sequence s_pin_held;
      pin_act [*5];
   endsequence
   a_aux_a_on: assert property (modem_ctrl_reg_a[3] |=> !aux_out_a_n && irq_out_a_oe)
      else $error("aux a on");
   a_aux_a_off: assert property (!modem_ctrl_reg_a[3] |=> aux_out_a_n && !irq_out_a_oe)
      else $error("aux a off");
   a_chan_b: assert property (1 |=> aux_out_b_n != irq_out_b_oe &&
      irq_out_b_oe == $past(modem_ctrl_reg_b[3])) else $error("aux b");
   a_rts_level: assert property (1 |=> req_send_b_n != $past(modem_ctrl_reg_b[1]))
      else $error("rts");
   a_dtr_level: assert property (1 |=> term_ready_b_n != $past(modem_ctrl_reg_b[0]))
      else $error("dtr");
   a_cts_sense: assert property (1 |=> tx_allowed_b != $past(clr_send_b_n))
      else $error("cts");
   a_bus_mode: assert property ($stable(bus_sel) [*2] |-> bus_mode == bus_sel)
      else $error("bus mode");
   a_pin_reset: assert property (disable iff (!reset_n) s_pin_held |-> dev_reset)
      else $error("pin reset");
endmodule
bind upco_top upco_assertions i_upco_assertions (.*);

// File: test/upco_peer.sv
// Serial modem peer on the channel B line side
`timescale 1ns/1ns
module upco_peer (
   input wire logic send,
   input wire logic [3:0] stat,
   output logic ser_in_b,
   output logic set_ready_b_n,
   output logic carrier_det_b_n,
   output logic ring_ind_b_n,
   output logic clr_send_b_n
);
   // Start bit while sending, mark otherwise
   assign ser_in_b = send ? 1'b0 : 1'b1;
   assign {set_ready_b_n, carrier_det_b_n, ring_ind_b_n, clr_send_b_n} = ~stat;
endmodule

// File: test/upco_tb_top.sv
// Bench for the pin control block
`timescale 1ns/1ns
module upco_tb_top;
   import upco_pkg::*;
   logic core_clk, reset_n = 1'b0, osc_in = 1'b1, bus_sel = 1'b0, reset_pin = 1'b1;
   logic irq_req_a = 1'b1, irq_req_b = 1'b1, tx_bit_b = 1'b0, send = 1'b1;
   logic [3:0] stat = 4'hf;
   logic [7:0] modem_ctrl_reg_a = 8'hff, modem_ctrl_reg_b = 8'hff;
   upco_bus_in_t bus_in = 6'h00;
   logic osc_out, aux_out_a_n, aux_out_b_n, irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe;
   logic ser_out_b, req_send_b_n, term_ready_b_n, rx_bit_b, tx_allowed_b, dev_reset, ser_in_b;
   logic set_ready_b_n, carrier_det_b_n, ring_ind_b_n, clr_send_b_n;
   upco_modem_stat_t modem_stat_b;
   upco_bus_mode_t bus_mode;
   upco_bus_req_t bus_req;
   int fails = 0, tests_run = 0;
   // Row: pins, bus strobes, modem lines, expected outputs
   logic [31:0] tbl [4] = '{32'hff569b3a, 32'h96a854a5, 32'h0c0d64c6, 32'h6953a259};
   upco_top i_upco_top (.*);
   upco_peer i_upco_peer (.*);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(3);
      chk({aux_out_a_n, irq_out_a_oe, irq_out_a, aux_out_b_n, irq_out_b_oe, irq_out_b,
         req_send_b_n, term_ready_b_n, bus_mode, ser_out_b, rx_bit_b, modem_stat_b, bus_req,
         dev_reset}, 32'h00093601);
      reset_n = 1'b1;
      foreach (tbl[k]) begin
         {modem_ctrl_reg_a[3], modem_ctrl_reg_b[3], modem_ctrl_reg_b[1:0], irq_req_a,
            irq_req_b, bus_sel, osc_in} = tbl[k][31:24];
         {bus_in, stat} = tbl[k][23:14];
         reset_pin = ~bus_sel;
         send = osc_in;
         tx_bit_b = irq_req_b;
         tick(5);
         chk({aux_out_a_n, irq_out_a_oe, irq_out_a, aux_out_b_n, irq_out_b_oe, irq_out_b,
            req_send_b_n, term_ready_b_n, bus_mode, osc_out, bus_req, modem_stat_b,
            tx_allowed_b, ser_out_b, rx_bit_b}, {tbl[k][13:0], tbl[k][17:14], tbl[k][14],
            tbl[k][26], ~tbl[k][24]});
      end
      modem_ctrl_reg_a[3] = 1'b1;
      for (int m = 0; m < 2; m++) begin
         bus_sel = m[0];
         reset_pin = m[0];
         tick(6);
         chk({dev_reset, aux_out_a_n, irq_out_a_oe}, 32'h6);
         reset_pin = ~m[0];
         tick(6);
         chk({dev_reset, aux_out_a_n, irq_out_a_oe}, 32'h1);
      end
      stop_test();
   end
endmodule
